// ---- logic/bcd_decade_arith_unit.sv ----
`timescale 1ns/100ps
`include "bcd_arith_cfg.svh"
module bcd_decade_arith_unit #(
  parameter int DECADES = `DECADES_DEF
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic count_up_i,
  input wire logic count_dn_i,
  input wire logic op_valid_i,
  input wire bcd_arith_pkg::arith_op_e op_i,
  input wire logic tens_cmp_i,
  input wire logic sign_a_i,
  input wire logic sign_b_i,
  input wire logic [4*DECADES-1:0] opa_i,
  input wire logic [4*DECADES-1:0] opb_i,
  output logic [4*DECADES-1:0] count_o,
  output logic count_carry_o,
  output logic count_borrow_o,
  output logic [4*DECADES-1:0] result_o,
  output logic sign_o,
  output logic carry_o,
  output logic result_valid_o
);
  import bcd_arith_pkg::*;

  localparam int W = 4 * DECADES;
  localparam int PW = 5 * DECADES + 2;

  // Packed answer: {sign, sign carry, decade carries, digits}.
  function automatic logic [PW-1:0] bin_add(input logic [W-1:0] a,
                                            input logic [W-1:0] b,
                                            input logic sa,
                                            input logic sb,
                                            input logic cin);
    logic [4:0] t;
    logic c;
    logic [W-1:0] s;
    logic [DECADES-1:0] dc;
    c = cin;
    s = '0;
    dc = '0;
    for (int i = 0; i < DECADES; i++) begin
      t = {1'b0, a[4*i+:4]} + {1'b0, b[4*i+:4]} + {4'h0, c};
      s[4*i+:4] = t[3:0];
      dc[i] = t[4];
      c = t[4];
    end
    return {sa ^ sb ^ c, (sa & sb) | (c & (sa ^ sb)), dc, s};
  endfunction : bin_add

  // Minus three folds the digit's own top carry back in, so no carry leaves it.
  function automatic logic [3:0] xs3_fix(input logic [3:0] d, input logic c);
    logic [4:0] t;
    t = {1'b0, d} + {1'b0, (c ? `XS3_PLUS3 : `XS3_MINUS3)};
    return c ? t[3:0] : t[3:0] + {3'h0, t[4]};
  endfunction : xs3_fix

  // Counter.
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic cy_out;
  logic bw_out;
  // Both commands at once count neither way, so the two chains never meet.
  wire up_go = count_up_i & ~count_dn_i;
  wire dn_go = count_dn_i & ~count_up_i;

  always_comb begin
    logic cy;
    logic bw;
    logic [3:0] d;
    cy = up_go;
    bw = dn_go;
    d = '0;
    next_cnt = cnt;
    for (int i = 0; i < DECADES; i++) begin
      d = cnt[4*i+:4];
      if (cy) begin
        if (d == `BCD_NINE) begin
          next_cnt[4*i+:4] = `BCD_ZERO;
        end else begin
          next_cnt[4*i+:4] = d + 4'h1;
          cy = 1'b0;
        end
      end else if (bw) begin
        if (d == `BCD_ZERO) begin
          next_cnt[4*i+:4] = `BCD_NINE;
        end else begin
          next_cnt[4*i+:4] = d - 4'h1;
          bw = 1'b0;
        end
      end
    end
    cy_out = cy;
    bw_out = bw;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
      count_carry_o <= 1'b0;
      count_borrow_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      count_carry_o <= cy_out;
      count_borrow_o <= bw_out;
    end
  end
  assign count_o = cnt;

  // 8421 adder: each decade corrected before its carry moves on.
  // A sum above 15 has already carried, yet its low four bits still need the six.
  logic [W-1:0] bcd_sum;
  logic bcd_cout;
  always_comb begin
    logic [4:0] t;
    logic c;
    t = '0;
    c = 1'b0;
    bcd_sum = '0;
    for (int i = 0; i < DECADES; i++) begin
      t = {1'b0, opa_i[4*i+:4]} + {1'b0, opb_i[4*i+:4]} + {4'h0, c};
      if (t > {1'b0, `BCD_NINE}) begin
        bcd_sum[4*i+:4] = t[3:0] + `BCD_SIX;
        c = 1'b1;
      end else begin
        bcd_sum[4*i+:4] = t[3:0];
        c = 1'b0;
      end
    end
    bcd_cout = c;
  end

  // Excess-3 path. Subtrahend is inverted, sign included.
  wire is_sub = (op_i == OP_SUB_XS3);
  wire [W-1:0] b_eff = is_sub ? ~opb_i : opb_i;
  wire sb_eff = is_sub ? ~sign_b_i : sign_b_i;
  wire cin_tens = is_sub & tens_cmp_i;
  wire [PW-1:0] pass1 = bin_add(opa_i, b_eff, sign_a_i, sb_eff, cin_tens);
  // Second pass re-adds the sign carry; in tens mode the loop is cut.
  wire eac = pass1[PW-2] & ~tens_cmp_i;
  wire [PW-1:0] pass2 = bin_add(opa_i, b_eff, sign_a_i, sb_eff, cin_tens | eac);
  wire [W-1:0] raw_sum = pass2[W-1:0];
  wire [DECADES-1:0] dec_cy = pass2[W+DECADES-1:W];
  logic [W-1:0] xs3_sum;
  always_comb begin
    xs3_sum = '0;
    for (int i = 0; i < DECADES; i++) begin
      xs3_sum[4*i+:4] = xs3_fix(raw_sum[4*i+:4], dec_cy[i]);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      result_o <= '0;
      sign_o <= 1'b0;
      carry_o <= 1'b0;
      result_valid_o <= 1'b0;
    end else begin
      result_valid_o <= op_valid_i;
      if (op_valid_i) begin
        unique case (op_i)
          OP_ADD_BCD: begin
            result_o <= bcd_sum;
            sign_o <= 1'b0;
            carry_o <= bcd_cout;
          end
          OP_ADD_XS3, OP_SUB_XS3: begin
            result_o <= xs3_sum;
            sign_o <= pass2[PW-1];
            carry_o <= pass1[PW-2];
          end
          OP_CMP_XS3: begin
            result_o <= ~opa_i;
            sign_o <= ~sign_a_i;
            carry_o <= 1'b0;
          end
        endcase
      end
    end
  end

  // Checks.
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  wire [4:0] lo_bin = {1'b0, opa_i[3:0]} + {1'b0, opb_i[3:0]};
  // Decade 1 sums for the checks; they assume at least two decades.
  wire [4:0] hi_bin = {1'b0, opa_i[7:4]} + {1'b0, opb_i[7:4]} + {4'h0, (lo_bin > 5'd9)};
  wire [4:0] x1_bin = {1'b0, opa_i[7:4]} + {1'b0, opb_i[7:4]} + {4'h0, lo_bin[4]};

  property p_up_wrap;
    up_go && cnt[3:0] == `BCD_NINE |=> cnt[3:0] == `BCD_ZERO;
  endproperty
  a_up_wrap: assert property (p_up_wrap) else $error("up wrap failed");

  property p_dn_wrap;
    dn_go && cnt[3:0] == `BCD_ZERO |=> cnt[3:0] == `BCD_NINE;
  endproperty
  a_dn_wrap: assert property (p_dn_wrap) else $error("down wrap failed");

  property p_no_both;
    count_up_i && count_dn_i |=> $stable(cnt) && !count_carry_o && !count_borrow_o;
  endproperty
  a_no_both: assert property (p_no_both) else $error("both counts acted");

  property p_bcd_pass;
    op_valid_i && op_i == OP_ADD_BCD && lo_bin <= 5'd9 |=>
      result_o[3:0] == $past(lo_bin[3:0]);
  endproperty
  a_bcd_pass: assert property (p_bcd_pass) else $error("bcd pass wrong");

  property p_bcd_mid;
    op_valid_i && op_i == OP_ADD_BCD && lo_bin >= 5'd10 && lo_bin <= 5'd15 |=>
      result_o[3:0] == $past(lo_bin[3:0]) + 4'h6;
  endproperty
  a_bcd_mid: assert property (p_bcd_mid) else $error("bcd six wrong");

  property p_bcd_high;
    op_valid_i && op_i == OP_ADD_BCD && lo_bin > 5'd15 |=>
      result_o[3:0] == $past(lo_bin[3:0]) + 4'h6;
  endproperty
  a_bcd_high: assert property (p_bcd_high) else $error("bcd high wrong");

  // An end-around carry lands in decade 0, so the check only holds without one.
  property p_xs3_minus;
    op_valid_i && op_i == OP_ADD_XS3 && !eac && lo_bin >= 5'd3 && lo_bin <= 5'd14 |=>
      result_o[3:0] == $past(lo_bin[3:0]) - 4'h3;
  endproperty
  a_xs3_minus: assert property (p_xs3_minus) else $error("minus three wrong");

  property p_cmp;
    op_valid_i && op_i == OP_CMP_XS3 |=>
      {sign_o, result_o} == ~$past({sign_a_i, opa_i}) && result_valid_o;
  endproperty
  a_cmp: assert property (p_cmp) else $error("complement wrong");

  property p_one_step;
    op_valid_i ##1 !op_valid_i |-> result_valid_o ##1 !result_valid_o;
  endproperty
  a_one_step: assert property (p_one_step) else $error("result timing wrong");

  // The wrap of one decade must step the decade above it.
  property p_up_carry;
    up_go && cnt[3:0] == `BCD_NINE && cnt[7:4] != `BCD_NINE |=>
      cnt[7:4] == $past(cnt[7:4]) + 4'h1;
  endproperty
  a_up_carry: assert property (p_up_carry) else $error("up carry lost");

  property p_dn_borrow;
    dn_go && cnt[3:0] == `BCD_ZERO && cnt[7:4] != `BCD_ZERO |=>
      cnt[7:4] == $past(cnt[7:4]) - 4'h1;
  endproperty
  a_dn_borrow: assert property (p_dn_borrow) else $error("down borrow lost");

  property p_up_all;
    up_go && cnt == {DECADES{`BCD_NINE}} |=> count_carry_o && cnt == '0;
  endproperty
  a_up_all: assert property (p_up_all) else $error("top carry wrong");

  property p_dn_all;
    dn_go && cnt == '0 |=> count_borrow_o && cnt == {DECADES{`BCD_NINE}};
  endproperty
  a_dn_all: assert property (p_dn_all) else $error("top borrow wrong");

  property p_bcd_ripple;
    op_valid_i && op_i == OP_ADD_BCD && hi_bin <= 5'd9 |=>
      result_o[7:4] == $past(hi_bin[3:0]);
  endproperty
  a_bcd_ripple: assert property (p_bcd_ripple) else $error("bcd ripple wrong");

  property p_xs3_plus;
    op_valid_i && op_i == OP_ADD_XS3 && !eac && lo_bin > 5'd15 |=>
      result_o[3:0] == $past(lo_bin[3:0]) + 4'h3;
  endproperty
  a_xs3_plus: assert property (p_xs3_plus) else $error("plus three wrong");

  // A fold inside decade 0 must never reach decade 1.
  property p_xs3_local;
    op_valid_i && op_i == OP_ADD_XS3 && !eac && x1_bin >= 5'd3 && x1_bin <= 5'd15 |=>
      result_o[7:4] == $past(x1_bin[3:0]) - 4'h3;
  endproperty
  a_xs3_local: assert property (p_xs3_local) else $error("fold leaked");

  // A value minus itself is negative zero, or positive zero in tens mode.
  property p_sub_self;
    op_valid_i && op_i == OP_SUB_XS3 && !tens_cmp_i &&
      opa_i == opb_i && sign_a_i == sign_b_i |=>
      sign_o && result_o == {DECADES{`XS3_MINUS3}};
  endproperty
  a_sub_self: assert property (p_sub_self) else $error("negative zero wrong");

  property p_sub_tens_zero;
    op_valid_i && op_i == OP_SUB_XS3 && tens_cmp_i &&
      opa_i == opb_i && sign_a_i == sign_b_i |=>
      !sign_o && result_o == {DECADES{`XS3_PLUS3}};
  endproperty
  a_sub_tens_zero: assert property (p_sub_tens_zero) else $error("tens zero wrong");

  c_up_wrap: cover property (up_go && cnt[3:0] == `BCD_NINE);
  c_sub_eac: cover property (op_valid_i && is_sub && eac);
  c_sub_tens: cover property (op_valid_i && is_sub && tens_cmp_i);
  c_bcd_high: cover property (op_valid_i && op_i == OP_ADD_BCD && lo_bin > 5'd15);
  c_add_neg: cover property (op_valid_i && op_i == OP_ADD_XS3 && eac);
endmodule : bcd_decade_arith_unit

// ---- pkg/bcd_arith_cfg.svh ----
`ifndef BCD_ARITH_CFG_SVH
`define BCD_ARITH_CFG_SVH
// Functional notes
// - Up count: a decade at 9 goes to 0 and carries onward.
// - Down count: a decade at 0 loads 9 and borrows onward.
// - Carry and borrow chains stay apart; up and down never act together.
// - 8421 decade sum of 9 or less passes unchanged.
// - 8421 decade sum 10 to 15 gets plus six and a carry.
// - 8421 decade sum above 15 keeps its carry and still gets six.
// - 8421 correction ripples decade by decade, corrected carry feeding next.
// - Excess-3 decade with carry gets plus three, without gets minus three.
// - Excess-3 correction passes no carry, all decades corrected at once.
// - Plus three adds 0011; minus three adds 1100 with own-carry fold.
// - Correction carry from a digit top bit returns to its own bottom bit.
// - Nines complement of an Excess-3 value inverts every bit, sign too.
// - Sign 0 positive, 1 negative; zero digits 0011 or 1100.
// - Subtract adds complemented subtrahend; carries ripple into sign bit.
// - Carry out of the sign bit re-enters the lowest decade; the code drops it whenever tens_cmp_i is set, additions included.
// - Subtraction uses the same per-decade plus/minus three correction.
// - Tens complement is nines complement plus one, no end-around carry.
`define DECADES_DEF 4
`define BCD_ZERO 4'h0
`define BCD_NINE 4'h9
`define BCD_SIX 4'h6
`define XS3_PLUS3 4'h3
`define XS3_MINUS3 4'hc
`endif

// ---- pkg/bcd_arith_pkg.sv ----
package bcd_arith_pkg;
  typedef enum logic [1:0] {
    OP_ADD_BCD,
    OP_ADD_XS3,
    OP_SUB_XS3,
    OP_CMP_XS3
  } arith_op_e;
endpackage : bcd_arith_pkg

// ---- test/op_ctrl_model.sv ----
`timescale 1ns/100ps
module op_ctrl_model #(
  parameter int W = 16
) (
  input wire logic req_i,
  input wire logic [W-1:0] a_i,
  input wire logic [W-1:0] b_i,
  output logic op_valid_o,
  output logic [W-1:0] opa_o,
  output logic [W-1:0] opb_o
);
  // Operands are only promised while a request stands, so idle cycles show the
  // inverse to expose any sampling outside the request.
  assign op_valid_o = req_i;
  assign opa_o = req_i ? a_i : ~a_i;
  assign opb_o = req_i ? b_i : ~b_i;
endmodule : op_ctrl_model

// ---- test/tb_bcd_decade_arith_unit.sv ----
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb_bcd_decade_arith_unit;
  import bcd_arith_pkg::*;
  logic clk_sys_i = 0, rst_n_i = 0, count_up_i = 0, count_dn_i = 0, req = 0;
  logic tens_cmp_i = 0, sign_a_i = 0, sign_b_i = 0, op_valid, cc, cb, sg, cy, rv;
  arith_op_e op_i = OP_ADD_BCD;
  logic [15:0] a = 0, b = 0, opa, opb, cnt_v, res;
  int err_total = 0, n_checks = 0;
  initial forever #5 clk_sys_i = ~clk_sys_i;
  op_ctrl_model #(.W(16)) op_ctrl_model_i (.req_i(req), .a_i(a), .b_i(b),
    .op_valid_o(op_valid), .opa_o(opa), .opb_o(opb));
  bcd_decade_arith_unit #(.DECADES(4)) bcd_decade_arith_unit_i (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .count_up_i(count_up_i), .count_dn_i(count_dn_i),
    .op_valid_i(op_valid), .op_i(op_i), .tens_cmp_i(tens_cmp_i), .sign_a_i(sign_a_i),
    .sign_b_i(sign_b_i), .opa_i(opa), .opb_i(opb), .count_o(cnt_v), .count_carry_o(cc),
    .count_borrow_o(cb), .result_o(res), .sign_o(sg), .carry_o(cy), .result_valid_o(rv));
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  task automatic cnt(input logic up, input logic dn, input int n);
    @(negedge clk_sys_i);
    count_up_i = up;
    count_dn_i = dn;
    repeat (n) @(negedge clk_sys_i);
    count_up_i = 0;
    count_dn_i = 0;
  endtask : cnt
  task automatic do_op(input arith_op_e op, input logic tc, input logic sa, input logic sb,
                       input logic [15:0] x, input logic [15:0] y, input logic [17:0] e);
    @(negedge clk_sys_i);
    op_i = op;
    tens_cmp_i = tc;
    sign_a_i = sa;
    sign_b_i = sb;
    a = x;
    b = y;
    req = 1;
    @(negedge clk_sys_i);
    req = 0;
    `CHK(rv, 1'b1)
    `CHK({cy, sg, res}, e)
  endtask : do_op
  task automatic t_count();
    cnt(1, 0, 9);
    `CHK(cnt_v, 16'h0009)
    cnt(1, 0, 1);
    `CHK(cnt_v, 16'h0010)
    cnt(1, 0, 9989);
    cnt(1, 0, 1);
    `CHK({cc, cnt_v}, 17'h10000)
    cnt(0, 1, 1);
    `CHK({cb, cnt_v}, 17'h19999)
    cnt(1, 1, 3);
    `CHK({cc, cb, cnt_v}, 18'h09999)
    cnt(0, 1, 9);
    cnt(0, 1, 1);
    `CHK({cb, cnt_v}, 17'h09989)
    $display("count test done");
  endtask : t_count
  task automatic t_bcd();
    do_op(OP_ADD_BCD, 0, 0, 0, 16'h0004, 16'h0003, 18'h00007);
    do_op(OP_ADD_BCD, 0, 0, 0, 16'h0008, 16'h0004, 18'h00012);
    do_op(OP_ADD_BCD, 0, 0, 0, 16'h0009, 16'h0008, 18'h00017);
    do_op(OP_ADD_BCD, 0, 0, 0, 16'h0999, 16'h0001, 18'h01000);
    do_op(OP_ADD_BCD, 0, 0, 0, 16'h9999, 16'h0001, 18'h20000);
    $display("8421 test done");
  endtask : t_bcd
  task automatic t_xs3();
    do_op(OP_ADD_XS3, 0, 0, 0, 16'h388b, 16'h3576, 18'h03b34);
    do_op(OP_SUB_XS3, 0, 0, 0, 16'h3384, 16'h3367, 18'h2334a);
    do_op(OP_SUB_XS3, 0, 0, 0, 16'h3367, 16'h3384, 18'h1ccb5);
    do_op(OP_SUB_XS3, 1, 0, 0, 16'h3384, 16'h3367, 18'h2334a);
    do_op(OP_SUB_XS3, 1, 0, 0, 16'h3367, 16'h3384, 18'h1ccb6);
    do_op(OP_CMP_XS3, 0, 0, 0, 16'h3384, 16'h0000, 18'h1cc7b);
    do_op(OP_CMP_XS3, 0, 0, 0, 16'h3333, 16'h0000, 18'h1cccc);
    do_op(OP_ADD_XS3, 0, 0, 0, 16'h3336, 16'h3337, 18'h0333a);
    do_op(OP_ADD_XS3, 0, 0, 1, 16'h3384, 16'hccb5, 18'h23367);
    do_op(OP_SUB_XS3, 0, 0, 0, 16'h3384, 16'h3384, 18'h1cccc);
    do_op(OP_SUB_XS3, 1, 0, 0, 16'h3384, 16'h3384, 18'h23333);
    $display("excess-3 test done");
  endtask : t_xs3
  initial begin
    #500000;
    err_total++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rst_n_i = 1;
    `CHK({cnt_v, res, cc, cb, sg, cy, rv}, 37'h0)
    t_count();
    t_bcd();
    t_xs3();
    conclude();
  end
endmodule : tb_bcd_decade_arith_unit
